/* File: hw/rtc_top.sv */
// Function
// R1 - keep seconds to year in bcd, hour in 12 or 24 hour form
// R2 - roll date by month length: 28, 29 in leap years, 30, 31
// R3 - programmable alarm and periodic events each raise the wakeup
// R4 - finest wakeup step is two low-speed ticks, about 61 us
// R5 - finest wakeup period spans 122 us to 4 s; reload 0 here gives 61 us
// R6 - coarser wakeup steps stretch the period up to 36 hours
// R7 - calendar periodic alarm every second up to every year
// R8 - one second per 32768 low-speed ticks, carries ripple to year
`timescale 1ns/1ps
`include "rtc_defines.svh"
module rtc_top
	import rtc_pkg::*;
#(
	parameter int SEC_DIV = `RTC_SEC_DIV
) (
	input wire logic clock,
	input wire logic resetn,
	input wire logic low_speed_external_clock_tick,
	input wire logic hour_12,
	input wire logic set_en,
	input wire logic [7:0] set_sec,
	input wire logic [7:0] set_min,
	input wire logic [7:0] set_hour,
	input wire logic set_pm,
	input wire logic [7:0] set_wday,
	input wire logic [7:0] set_date,
	input wire logic [7:0] set_month,
	input wire logic [7:0] set_year,
	input wire logic alarm_en,
	input wire logic [7:0] alarm_sec,
	input wire logic [7:0] alarm_min,
	input wire logic [7:0] alarm_hour,
	input wire logic alarm_pm,
	input wire logic [7:0] alarm_date,
	input wire logic [3:0] alarm_mask,
	input wire logic alarm_clear,
	input wire logic per_en,
	input wire rtc_per_e per_sel,
	input wire logic per_clear,
	input wire logic wut_en,
	input wire rtc_wsel_e wut_sel,
	input wire logic [15:0] wut_reload,
	input wire logic wut_clear,
	output rtc_bcd_t sec,
	output rtc_bcd_t min,
	output rtc_bcd_t hour,
	output logic pm,
	output rtc_bcd_t wday,
	output rtc_bcd_t date,
	output rtc_bcd_t month,
	output rtc_bcd_t year,
	output logic alarm_flag,
	output logic per_flag,
	output logic wut_flag,
	output logic wakeup
);
	// {carry, next}; wraps from top to low
	function automatic logic [8:0] f_bcd_inc(input logic [7:0] v,
			input logic [7:0] top, input logic [7:0] low);
		if (v == top)
			return {1'b1, low};
		else if (v[3:0] == 4'h9)
			return {1'b0, v[7:4] + 4'h1, 4'h0};
		else
			return {1'b0, v + 8'h01};
	endfunction : f_bcd_inc

	// two-digit years only, so every fourth year is leap
	function automatic logic f_leap(input logic [7:0] y);
		if (y[4])
			return (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
		else
			return (y[3:0] == 4'h0) || (y[3:0] == 4'h4) || (y[3:0] == 4'h8);
	endfunction : f_leap

	function automatic logic [7:0] f_month_end(input logic [7:0] m,
			input logic [7:0] y);
		if (m == `RTC_FEB)
			return f_leap(y) ? 8'h29 : 8'h28; // R2
		else if (m == 8'h04 || m == 8'h06 || m == 8'h09 || m == 8'h11)
			return 8'h30; // R2
		else
			return 8'h31; // R2
	endfunction : f_month_end

	rtc_wut_if wif ();
	logic [15:0] pre;
	logic sec_upd;

	wire low_speed_external_clock = low_speed_external_clock_tick;
	wire sec_tick = low_speed_external_clock && (pre == 16'(SEC_DIV - 1)); // R8
	wire [8:0] inc_sec = f_bcd_inc(sec, `RTC_MAX_SEC, 8'h00);
	wire [8:0] inc_min = f_bcd_inc(min, `RTC_MAX_MIN, 8'h00);
	wire [8:0] inc_h24 = f_bcd_inc(hour, `RTC_MAX_HOUR24, 8'h00);
	wire [8:0] inc_h12 = f_bcd_inc(hour, `RTC_MAX_HOUR12, 8'h01);
	wire [8:0] inc_wday = f_bcd_inc(wday, `RTC_MAX_WDAY, 8'h01);
	wire [8:0] inc_date = f_bcd_inc(date, f_month_end(month, year), 8'h01);
	wire [8:0] inc_month = f_bcd_inc(month, `RTC_MAX_MONTH, 8'h01);
	wire [8:0] inc_year = f_bcd_inc(year, `RTC_MAX_YEAR, 8'h00);

	// carry chain, one level per field
	wire c_sec = sec_tick && inc_sec[8]; // R8
	wire c_min = c_sec && inc_min[8]; // R8
	wire eve = hour == `RTC_HOUR12_EVE;
	wire c_hour = c_min && (hour_12 ? (eve && pm) : inc_h24[8]); // R1
	wire c_date = c_hour && inc_date[8]; // R2
	wire c_month = c_date && inc_month[8]; // R8

	wire [7:0] next_hour = hour_12 ? inc_h12[7:0] : inc_h24[7:0]; // R1
	wire next_pm = hour_12 && (pm ^ eve); // R1

	// periodic alarm picks the carry into the chosen field
	logic per_hit;
	always_comb begin
		case (per_sel)
			RTC_PER_SEC: per_hit = sec_tick; // R7
			RTC_PER_MIN: per_hit = c_sec; // R7
			RTC_PER_HOUR: per_hit = c_min; // R7
			RTC_PER_DAY: per_hit = c_hour; // R7
			RTC_PER_MONTH: per_hit = c_date; // R7
			RTC_PER_YEAR: per_hit = c_month; // R7
			default: per_hit = 1'b0;
		endcase
	end

	// compared one cycle after the update so the new time is seen
	wire match_sec = alarm_mask[`RTC_AMSK_SEC] || sec == alarm_sec;
	wire match_min = alarm_mask[`RTC_AMSK_MIN] || min == alarm_min;
	wire match_hour = alarm_mask[`RTC_AMSK_HOUR]
		|| (hour == alarm_hour && (!hour_12 || pm == alarm_pm));
	wire match_date = alarm_mask[`RTC_AMSK_DATE] || date == alarm_date;
	wire alarm_hit = alarm_en && sec_upd
		&& match_sec && match_min && match_hour && match_date; // R3

	// set wins over clear so no event is dropped
	wire next_alarm = alarm_hit || (alarm_flag && !alarm_clear); // R3
	wire next_per = (per_en && per_hit && !set_en)
		|| (per_flag && !per_clear); // R7
	wire next_wut = wif.fire || (wut_flag && !wut_clear); // R3

	assign wif.lse_tick = low_speed_external_clock;
	assign wif.sec_tick = sec_tick && !set_en;
	assign wif.en = wut_en;
	assign wif.sel = wut_sel;
	assign wif.reload = wut_reload;

	rtc_wakeup u_wakeup (
		.clock(clock),
		.resetn(resetn),
		.wif(wif)
	);

	// writing the time restarts the second so it is a full second
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn)
			pre <= 16'h0;
		else if (set_en || sec_tick)
			pre <= 16'h0; // R8
		else if (low_speed_external_clock)
			pre <= pre + 16'h1; // R8
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			sec <= `RTC_RST_SEC;
			min <= `RTC_RST_MIN;
			hour <= `RTC_RST_HOUR;
			pm <= 1'b0;
			wday <= `RTC_RST_WDAY;
			date <= `RTC_RST_DATE;
			month <= `RTC_RST_MONTH;
			year <= `RTC_RST_YEAR;
		end else if (set_en) begin
			sec <= set_sec;
			min <= set_min;
			hour <= set_hour;
			pm <= set_pm && hour_12;
			wday <= set_wday;
			date <= set_date;
			month <= set_month;
			year <= set_year;
		end else if (sec_tick) begin
			sec <= inc_sec[7:0]; // R8
			if (c_sec)
				min <= inc_min[7:0]; // R8
			if (c_min) begin
				hour <= next_hour; // R1
				pm <= next_pm; // R1
			end
			if (c_hour) begin
				wday <= inc_wday[7:0]; // R8
				date <= inc_date[7:0]; // R2
			end
			if (c_date)
				month <= inc_month[7:0]; // R8
			if (c_month)
				year <= inc_year[7:0]; // R8
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			sec_upd <= 1'b0;
			alarm_flag <= 1'b0;
			per_flag <= 1'b0;
			wut_flag <= 1'b0;
			wakeup <= 1'b0;
		end else begin
			sec_upd <= sec_tick && !set_en;
			alarm_flag <= next_alarm;
			per_flag <= next_per;
			wut_flag <= next_wut;
			wakeup <= next_alarm || next_per || next_wut; // R3
		end
	end

	property p_sec_wrap;
		@(posedge clock) disable iff (!resetn)
		sec_tick && !set_en && sec == 8'h59 && min == 8'h59
			|=> sec == 8'h00 && min == 8'h00;
	endproperty
	a_sec_wrap: assert property (p_sec_wrap) else $error("bad carry"); // R8

	property p_leap_feb;
		@(posedge clock) disable iff (!resetn)
		c_hour && !set_en && month == 8'h02 && date == 8'h28
			&& year == 8'h24 |=> date == 8'h29 && month == 8'h02;
	endproperty
	a_leap_feb: assert property (p_leap_feb) else $error("leap day"); // R2

	property p_feb_end;
		@(posedge clock) disable iff (!resetn)
		c_hour && !set_en && month == 8'h02 && date == 8'h28
			&& year == 8'h23 |=> date == 8'h01 && month == 8'h03;
	endproperty
	a_feb_end: assert property (p_feb_end) else $error("feb end"); // R2

	property p_apr_end;
		@(posedge clock) disable iff (!resetn)
		c_hour && !set_en && month == 8'h04 && date == 8'h30
			|=> date == 8'h01 && month == 8'h05;
	endproperty
	a_apr_end: assert property (p_apr_end) else $error("30 day"); // R2

	property p_noon;
		@(posedge clock) disable iff (!resetn)
		hour_12 && c_min && !set_en && hour == 8'h11 && !pm
			|=> hour == 8'h12 && pm;
	endproperty
	a_noon: assert property (p_noon) else $error("12 hour"); // R1

	property p_alarm;
		@(posedge clock) disable iff (!resetn)
		alarm_hit |=> alarm_flag && wakeup;
	endproperty
	a_alarm: assert property (p_alarm) else $error("alarm lost"); // R3

	property p_per_sec;
		@(posedge clock) disable iff (!resetn)
		per_en && per_sel == RTC_PER_SEC && sec_tick && !set_en
			|=> per_flag && wakeup;
	endproperty
	a_per_sec: assert property (p_per_sec) else $error("periodic"); // R7

	property p_flag_hold;
		@(posedge clock) disable iff (!resetn)
		wut_flag && !wut_clear |=> wut_flag && wakeup;
	endproperty
	a_flag_hold: assert property (p_flag_hold) else $error("flag drop"); // R3

endmodule : rtc_top

/* File: hw/rtc_defines.svh */
`ifndef RTC_DEFINES_SVH
`define RTC_DEFINES_SVH

// low-speed clock ticks per second
`define RTC_SEC_DIV 32768

// calendar reset values, bcd
`define RTC_RST_SEC 8'h00
`define RTC_RST_MIN 8'h00
`define RTC_RST_HOUR 8'h00
`define RTC_RST_WDAY 8'h01
`define RTC_RST_DATE 8'h01
`define RTC_RST_MONTH 8'h01
`define RTC_RST_YEAR 8'h00

// calendar field limits, bcd
`define RTC_MAX_SEC 8'h59
`define RTC_MAX_MIN 8'h59
`define RTC_MAX_HOUR24 8'h23
`define RTC_MAX_HOUR12 8'h12
`define RTC_HOUR12_EVE 8'h11
`define RTC_MAX_WDAY 8'h07
`define RTC_MAX_MONTH 8'h12
`define RTC_MAX_YEAR 8'h99
`define RTC_FEB 8'h02

// alarm mask bit positions
`define RTC_AMSK_SEC 0
`define RTC_AMSK_MIN 1
`define RTC_AMSK_HOUR 2
`define RTC_AMSK_DATE 3

// wakeup reload reset value
`define RTC_RST_RELOAD 16'hffff

`endif

/* File: hw/rtc_pkg.sv */
package rtc_pkg;

	typedef logic [7:0] rtc_bcd_t;

	// periodic alarm repetition
	typedef enum logic [2:0] {
		RTC_PER_SEC = 3'h0,
		RTC_PER_MIN = 3'h1,
		RTC_PER_HOUR = 3'h2,
		RTC_PER_DAY = 3'h3,
		RTC_PER_MONTH = 3'h4,
		RTC_PER_YEAR = 3'h5
	} rtc_per_e;

	// wakeup step source
	typedef enum logic [2:0] {
		RTC_WSEL_DIV16 = 3'h0,
		RTC_WSEL_DIV8 = 3'h1,
		RTC_WSEL_DIV4 = 3'h2,
		RTC_WSEL_DIV2 = 3'h3,
		RTC_WSEL_SEC = 3'h4,
		RTC_WSEL_SEC_B = 3'h5,
		RTC_WSEL_SEC17 = 3'h6,
		RTC_WSEL_SEC17_B = 3'h7
	} rtc_wsel_e;

endpackage : rtc_pkg

/* File: hw/rtc_wut_if.sv */
`timescale 1ns/1ps
interface rtc_wut_if;
	import rtc_pkg::*;
	logic lse_tick;
	logic sec_tick;
	logic en;
	rtc_wsel_e sel;
	logic [15:0] reload;
	logic fire;
	modport top (output lse_tick, sec_tick, en, sel, reload, input fire);
	modport timer (input lse_tick, sec_tick, en, sel, reload, output fire);
endinterface : rtc_wut_if

/* File: hw/rtc_wakeup.sv */
`timescale 1ns/1ps
`include "rtc_defines.svh"
module rtc_wakeup
	import rtc_pkg::*;
(
	input wire logic clock,
	input wire logic resetn,
	rtc_wut_if.timer wif
);
	logic [3:0] div;
	logic [16:0] cnt;
	wire wide = (wif.sel == RTC_WSEL_SEC17) || (wif.sel == RTC_WSEL_SEC17_B);
	wire [16:0] full = {wide, wif.reload};
	logic step;

	// one step is 2..16 low-speed ticks, or one second
	always_comb begin
		case (wif.sel)
			RTC_WSEL_DIV16: step = wif.lse_tick && (div == 4'hf); // R6
			RTC_WSEL_DIV8: step = wif.lse_tick && (div[2:0] == 3'h7); // R6
			RTC_WSEL_DIV4: step = wif.lse_tick && (div[1:0] == 2'h3); // R6
			RTC_WSEL_DIV2: step = wif.lse_tick && div[0]; // R4
			default: step = wif.sec_tick; // R6
		endcase
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn)
			div <= 4'h0;
		else if (wif.lse_tick)
			div <= div + 4'h1;
	end

	// period is reload+1 steps, plus 65536 in the SEC17 modes; reload 0 gives the shortest period
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			cnt <= 17'h0;
			wif.fire <= 1'b0;
		end else if (!wif.en) begin
			cnt <= full;
			wif.fire <= 1'b0;
		end else if (step) begin
			cnt <= (cnt == 17'h0) ? full : cnt - 17'h1; // R5
			wif.fire <= (cnt == 17'h0);
		end else begin
			wif.fire <= 1'b0;
		end
	end

	property p_wut_reload;
		@(posedge clock) disable iff (!resetn)
		wif.fire && wif.en && $stable(wif.sel) && $stable(wif.reload)
			|-> cnt == full;
	endproperty
	a_wut_reload: assert property (p_wut_reload) else $error("reload lost"); // R5

	property p_wut_fire;
		@(posedge clock) disable iff (!resetn)
		wif.en && step && cnt == 17'h0 |=> wif.fire;
	endproperty
	a_wut_fire: assert property (p_wut_fire) else $error("no wakeup"); // R3

endmodule : rtc_wakeup

/* File: tb/rtc_top_tb_top.sv */
`timescale 1ns/1ps
module rtc_top_tb_top;
	import rtc_pkg::*;
	// short second keeps the run small
	localparam int SD = 4;
	logic clock = 0, resetn = 0, tick = 0, hour_12 = 0, set_en = 0;
	logic [7:0] set_sec = 0, set_min = 0, set_hour = 0, set_wday = 1;
	logic [7:0] set_date = 1, set_month = 1, set_year = 0;
	logic [7:0] alarm_sec = 0, alarm_min = 0, alarm_hour = 0;
	logic [7:0] alarm_date = 1;
	logic set_pm = 0, alarm_pm = 0, alarm_en = 0, alarm_clear = 0;
	logic [3:0] alarm_mask = 0;
	logic per_en = 0, per_clear = 0, wut_en = 0, wut_clear = 0;
	rtc_per_e per_sel = RTC_PER_SEC;
	rtc_wsel_e wut_sel = RTC_WSEL_DIV16;
	logic [15:0] wut_reload = 0;
	rtc_bcd_t sec, min, hour, wday, date, month, year;
	logic pm, alarm_flag, per_flag, wut_flag, wakeup;
	int miscompares = 0, n_tests = 0;

	rtc_top #(.SEC_DIV(SD)) u_rtc_top (.clock, .resetn,
		.low_speed_external_clock_tick(tick), .hour_12, .set_en,
		.set_sec, .set_min, .set_hour, .set_pm, .set_wday, .set_date,
		.set_month, .set_year, .alarm_en, .alarm_sec, .alarm_min,
		.alarm_hour, .alarm_pm, .alarm_date, .alarm_mask, .alarm_clear,
		.per_en, .per_sel, .per_clear, .wut_en, .wut_sel, .wut_reload,
		.wut_clear, .sec, .min, .hour, .pm, .wday, .date, .month, .year,
		.alarm_flag, .per_flag, .wut_flag, .wakeup);

	initial begin
		forever #5 clock = ~clock;
	end

	task automatic chk(string n, logic [31:0] g, logic [31:0] e);
		n_tests++;
		if (g !== e) begin
			miscompares++;
			$display("[ERR] %s exp %h got %h", n, e, g);
		end
	endtask : chk

	task automatic cyc(int n);
		repeat (n) @(posedge clock);
	endtask : cyc

	// idle gap lets flags settle before the next tick
	task automatic ticks(int n);
		repeat (n) begin
			tick <= 1;
			cyc(1);
			tick <= 0;
			cyc(4);
		end
	endtask : ticks

	task automatic conclude;
		$display("compares %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : conclude

	task automatic rst_test;
		resetn <= 0;
		cyc(2);
		chk("rst_time", {sec, min, hour, wday}, 32'h00000001);
		chk("rst_day", {date, month, year, 3'h0, pm, alarm_flag, per_flag,
			wut_flag, wakeup}, 32'h01010000);
		resetn <= 1;
		cyc(1);
		$display("reset test done");
	endtask : rst_test

	// loads hh:59:59, weekday 7, and clears the alarm and periodic flags
	task automatic setc(logic [7:0] h, d, mo, y, logic p);
		set_sec <= 8'h59;
		set_min <= 8'h59;
		set_wday <= 8'h07;
		set_hour <= h;
		set_date <= d;
		set_month <= mo;
		set_year <= y;
		set_pm <= p;
		set_en <= 1;
		cyc(1);
		set_en <= 0;
		alarm_clear <= 1;
		per_clear <= 1;
		cyc(1);
		alarm_clear <= 0;
		per_clear <= 0;
		cyc(1);
	endtask : setc

	task automatic roll(logic [7:0] d, mo, y, ed, emo, ey);
		setc(8'h23, d, mo, y, 0);
		ticks(SD - 1);
		chk("early", sec, 8'h59);
		ticks(1);
		chk("time", {sec, min, hour, wday}, 32'h00000001);
		chk("day", {date, month, year}, {ed, emo, ey});
		$display("roll test %h/%h/%h done", y, mo, d);
	endtask : roll

	task automatic h12(logic [7:0] h, logic p, logic [7:0] eh, logic ep,
		logic [7:0] ed);
		hour_12 <= 1;
		setc(h, 8'h10, 8'h05, 8'h05, p);
		ticks(SD);
		chk("hour12", {hour, 7'h0, pm, date}, {eh, 7'h0, ep, ed});
		hour_12 <= 0;
		$display("12 hour test %h done", h);
	endtask : h12

	// date field matches, mismatches, then is masked off
	task automatic alarm_test;
		alarm_en <= 1;
		for (int i = 0; i < 3; i++) begin
			alarm_date <= (i == 0) ? 8'h01 : 8'h02;
			alarm_mask <= (i == 2) ? 4'h8 : 4'h0;
			setc(8'h23, 8'h31, 8'h01, 8'h05, 0);
			chk("alarm_pre", alarm_flag, 0);
			ticks(SD);
			chk("alarm", {alarm_flag, wakeup}, (i != 1) ? 3 : 0);
		end
		alarm_en <= 0;
		$display("alarm test done");
	endtask : alarm_test

	// jan 31 carries all but the year; dec 31 carries the year too
	task automatic per_test;
		per_en <= 1;
		for (int i = 0; i < 7; i++) begin
			per_sel <= rtc_per_e'((i < 6) ? i : 5);
			setc(8'h23, 8'h31, (i < 6) ? 8'h01 : 8'h12, 8'h05, 0);
			ticks(SD);
			chk("periodic", {per_flag, wakeup}, (i != 5) ? 3 : 0);
		end
		per_en <= 0;
		$display("periodic test done");
	endtask : per_test

	// first fire has free-running divider phase, so the second is timed
	task automatic wut_test;
		int n;
		for (int s = 0; s < 6; s++) begin
			wut_en <= 0;
			wut_sel <= rtc_wsel_e'(s);
			wut_reload <= 16'(s);
			cyc(2);
			wut_en <= 1;
			for (int k = 0; k < 2; k++) begin
				wut_clear <= 1;
				cyc(1);
				wut_clear <= 0;
				cyc(1);
				n = 0;
				while (wut_flag !== 1'b1 && n < 200) begin
					ticks(1);
					n++;
				end
				if (n >= 200) begin
					miscompares++;
					conclude();
				end
			end
			chk("wut", n, (s + 1) * ((s < 4) ? (16 >> s) : SD));
			chk("wut_wake", wakeup, 1);
		end
		wut_en <= 0;
		$display("wakeup timer test done");
	endtask : wut_test

	initial begin
		rst_test();
		roll(8'h28, 8'h02, 8'h23, 8'h01, 8'h03, 8'h23);
		roll(8'h28, 8'h02, 8'h24, 8'h29, 8'h02, 8'h24);
		roll(8'h29, 8'h02, 8'h12, 8'h01, 8'h03, 8'h12);
		roll(8'h30, 8'h04, 8'h05, 8'h01, 8'h05, 8'h05);
		roll(8'h30, 8'h01, 8'h05, 8'h31, 8'h01, 8'h05);
		roll(8'h31, 8'h12, 8'h99, 8'h01, 8'h01, 8'h00);
		h12(8'h11, 0, 8'h12, 1, 8'h10);
		h12(8'h11, 1, 8'h12, 0, 8'h11);
		h12(8'h12, 1, 8'h01, 1, 8'h10);
		alarm_test();
		per_test();
		wut_test();
		rst_test();
		conclude();
	end
endmodule : rtc_top_tb_top
